/* rtl/csf_flag_calc.sv */
`timescale 1ns/1ps
`default_nettype none
`include "csf_params.svh"

// combinational flag generator for one datapath operation
module csf_flag_calc (
  input wire csf_pkg::csf_exec_type exe,
  input wire logic carry_in,
  output var csf_pkg::csf_upd_type upd
);

  logic [8:0] res;
  logic [4:0] low;
  logic h;
  logic v;
  logic n;
  logic z;
  logic c;
  logic [7:0] sel;

  // arithmetic core and per-operation flag subset
  always_comb begin
    res = 9'h000;
    low = 5'h00;
    h = 1'b0;
    v = 1'b0;
    c = 1'b0;
    sel = 8'h00;
    upd.value = 8'h00;
    upd.mask = 8'h00;
    case (exe.op)
      csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_ADC: begin
        res = {1'b0, exe.a} + {1'b0, exe.b} +
          {8'h00, carry_in & (exe.op == csf_pkg::CSF_OP_ADC)};
        low = {1'b0, exe.a[3:0]} + {1'b0, exe.b[3:0]} +
          {4'h0, carry_in & (exe.op == csf_pkg::CSF_OP_ADC)};
        h = low[4];
        v = (exe.a[7] == exe.b[7]) && (res[7] != exe.a[7]);
        c = res[8];
        upd.mask = 8'h3f;
      end
      csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_SBC: begin
        res = {1'b0, exe.a} - {1'b0, exe.b} -
          {8'h00, carry_in & (exe.op == csf_pkg::CSF_OP_SBC)};
        low = {1'b0, exe.a[3:0]} - {1'b0, exe.b[3:0]} -
          {4'h0, carry_in & (exe.op == csf_pkg::CSF_OP_SBC)};
        h = low[4];
        v = (exe.a[7] != exe.b[7]) && (res[7] != exe.a[7]);
        c = res[8];
        upd.mask = 8'h3f;
      end
      csf_pkg::CSF_OP_LOGIC: begin
        res = {1'b0, exe.a};
        upd.mask = 8'h1e; // v cleared, c kept
      end
      csf_pkg::CSF_OP_SHIFT: begin
        res = {exe.a[0], 1'b0, exe.a[7:1]};
        c = exe.a[0];
        upd.mask = 8'h1f;
      end
      csf_pkg::CSF_OP_INC: begin
        res = {1'b0, exe.a + 8'h01};
        v = (exe.a == 8'h7f);
        upd.mask = 8'h1e;
      end
      csf_pkg::CSF_OP_DEC: begin
        res = {1'b0, exe.a - 8'h01};
        v = (exe.a == 8'h80);
        upd.mask = 8'h1e;
      end
      // RULE_05 enable instructions
      csf_pkg::CSF_OP_IRQ_EN: begin
        upd.mask[`CSF_BIT_I] = 1'b1;
        upd.value[`CSF_BIT_I] = 1'b1;
      end
      csf_pkg::CSF_OP_IRQ_DIS: begin
        upd.mask[`CSF_BIT_I] = 1'b1;
      end
      // RULE_07 bit store
      csf_pkg::CSF_OP_BIT_STORE: begin
        upd.mask[`CSF_BIT_T] = 1'b1;
        upd.value[`CSF_BIT_T] = exe.a[exe.bit_sel];
      end
      csf_pkg::CSF_OP_FLAG_SET, csf_pkg::CSF_OP_FLAG_CLR: begin
        sel = 8'h01 << exe.bit_sel;
        upd.mask = sel;
        upd.value = (exe.op == csf_pkg::CSF_OP_FLAG_SET) ? sel : 8'h00;
      end
      default: begin
        upd.mask = 8'h00;
      end
    endcase
    n = res[7];
    z = (res[7:0] == 8'h00);
    // single flag ops must keep their own value, even on the n bit
    if (upd.mask[`CSF_BIT_N] && exe.op != csf_pkg::CSF_OP_FLAG_SET &&
      exe.op != csf_pkg::CSF_OP_FLAG_CLR) begin
      // RULE_08 half carry
      upd.value[`CSF_BIT_H] = h;
      // RULE_10 signed overflow
      upd.value[`CSF_BIT_V] = v;
      // RULE_11 negative result
      upd.value[`CSF_BIT_N] = n;
      // RULE_12 zero result
      upd.value[`CSF_BIT_Z] = z;
      // RULE_13 carry out
      upd.value[`CSF_BIT_C] = c;
      // RULE_09 sign from n xor v
      upd.value[`CSF_BIT_S] = n ^ v;
    end
  end

endmodule : csf_flag_calc

`default_nettype wire

/* rtl/csf_params.svh */
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

// register offset and reset value
`define CSF_OFFSET 8'h0f
`define CSF_RESET 8'h00

// flag positions
`define CSF_BIT_I 7
`define CSF_BIT_T 6
`define CSF_BIT_H 5
`define CSF_BIT_S 4
`define CSF_BIT_V 3
`define CSF_BIT_N 2
`define CSF_BIT_Z 1
`define CSF_BIT_C 0

// wait cycles added to an i/o access that changes the enable bit
`define CSF_IRQ_WAIT 1

`endif

/* rtl/csf_pkg.sv */
package csf_pkg;

  // operation classes issued by the execution datapath
  typedef enum logic [3:0] {
    CSF_OP_NONE,
    CSF_OP_ADD,
    CSF_OP_ADC,
    CSF_OP_SUB,
    CSF_OP_SBC,
    CSF_OP_LOGIC,
    CSF_OP_SHIFT,
    CSF_OP_INC,
    CSF_OP_DEC,
    CSF_OP_IRQ_EN,
    CSF_OP_IRQ_DIS,
    CSF_OP_BIT_STORE,
    CSF_OP_FLAG_SET,
    CSF_OP_FLAG_CLR
  } csf_op_type;

  // one result handed over from the datapath
  typedef struct packed {
    logic valid;
    csf_op_type op;
    logic [7:0] a;
    logic [7:0] b;
    logic [2:0] bit_sel;
  } csf_exec_type;

  // i/o space access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csf_io_type;

  // flags computed for one operation and the bits they touch
  typedef struct packed {
    logic [7:0] value;
    logic [7:0] mask;
  } csf_upd_type;

endpackage : csf_pkg

/* rtl/csf_status_flags.sv */
`timescale 1ns/1ps
`default_nettype none
`include "csf_params.svh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// RULE_01: the register holds the last result flags and resets to zero.
// RULE_02: a one in bit 7 lets interrupts be taken anywhere; the gate still holds irq_take low while isr_enter or irq_return is high.
// RULE_03: a zero in bit 7 blocks every interrupt regardless of sources.
// RULE_04: isr entry and interrupt return leave bit 7 untouched.
// RULE_05: the enable and disable instructions set and clear bit 7.
// RULE_06: an i/o access changing bit 7 gets one wait cycle.
// RULE_07: bit 6 is written by bit store and read by bit load.
// RULE_08: bit 5 shows carry out of the low nibble where supported.
// RULE_09: bit 4 always equals negative xor overflow; flag set/clear ops and i/o writes can leave it otherwise.
// RULE_10: bit 3 shows signed overflow where supported.
// RULE_11: bit 2 shows a negative result.
// RULE_12: bit 1 shows a zero result.
// RULE_13: bit 0 shows a carry.
// RULE_14: flags an operation does not touch keep their value.
// RULE_15: an i/o write replaces all eight bits.
module csf_status_flags (
  input wire logic clk,
  input wire logic resetn,
  input wire csf_pkg::csf_exec_type exe,
  input wire csf_pkg::csf_io_type io,
  input wire logic irq_pending,
  input wire logic isr_enter,
  input wire logic irq_return,
  output logic [7:0] status_flags,
  output logic [7:0] io_rdata,
  output logic io_wait,
  output logic irq_take,
  output logic transfer_bit
);

  csf_pkg::csf_upd_type upd;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic hit;
  logic irq_change;

  //////////////////////////////////////////////////////////////////////////
  // flag computation
  csf_flag_calc u_calc (
    .exe(exe),
    .carry_in(flags_r[`CSF_BIT_C]),
    .upd(upd)
  );

  assign hit = (io.addr == `CSF_OFFSET);
  // RULE_06 detect enable change
  assign irq_change = io.wr && hit &&
    (io.wdata[`CSF_BIT_I] != flags_r[`CSF_BIT_I]);

  // next value: i/o write overrides a datapath update
  always_comb begin
    flags_nxt = flags_r;
    if (io.wr && hit) begin
      // RULE_15 full replace
      flags_nxt = io.wdata;
    end else if (exe.valid) begin
      // RULE_14 masked update
      flags_nxt = (flags_r & ~upd.mask) | (upd.value & upd.mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // RULE_01 flag register
  // isr_enter and irq_return are deliberately not used here
  // RULE_04 enable untouched by hw
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flags_r <= `CSF_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_flags <= `CSF_RESET;
      io_rdata <= 8'h00;
      io_wait <= 1'b0;
      transfer_bit <= 1'b0;
    end else begin
      status_flags <= flags_nxt;
      io_rdata <= (io.rd && hit) ? flags_r : 8'h00;
      // RULE_06 one wait cycle
      io_wait <= irq_change;
      // RULE_07 t bit for bit load
      transfer_bit <= flags_nxt[`CSF_BIT_T];
    end
  end

  // RULE_02 RULE_03 interrupt gate
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_take <= 1'b0;
    end else begin
      irq_take <= irq_pending && flags_nxt[`CSF_BIT_I] && !isr_enter &&
        !irq_return;
    end
  end

endmodule : csf_status_flags

`default_nettype wire

/* tb/csf_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module csf_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire csf_pkg::csf_exec_type exe,
  input wire csf_pkg::csf_io_type io,
  input wire logic irq_pending,
  input wire logic isr_enter,
  input wire logic irq_return,
  input wire logic [7:0] status_flags,
  input wire logic io_wait,
  input wire logic irq_take,
  input wire logic transfer_bit
);
  // decoded requests
  wire logic hit = io.wr && io.addr == 8'h0f;
  wire logic go = exe.valid && !hit;
  wire logic quiet = !exe.valid && !hit;
  wire logic chg = hit && io.wdata[7] != status_flags[7];
  wire logic en = exe.op == csf_pkg::CSF_OP_IRQ_EN;
  wire logic dis = exe.op == csf_pkg::CSF_OP_IRQ_DIS;
  wire logic st = exe.op == csf_pkg::CSF_OP_BIT_STORE;
  wire logic ar = exe.op inside {[csf_pkg::CSF_OP_ADD:csf_pkg::CSF_OP_DEC]};
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  io_write_a:
    assert property (hit |=> status_flags == $past(io.wdata))
    else $error("io write");
  wait_cycle_a:
    assert property (1 |=> io_wait == $past(chg)) else $error("wait");
  irq_block_a:
    assert property (irq_take |-> status_flags[7]) else $error("block");
  irq_take_a:
    assert property (irq_pending && status_flags[7] && quiet && !isr_enter
      && !irq_return |=> irq_take) else $error("take");
  isr_keep_a:
    assert property ((isr_enter || irq_return) && quiet
      |=> $stable(status_flags[7]) && !irq_take) else $error("isr");
  irq_instr_a:
    assert property (go && (en || dis) |=> status_flags[7] == $past(en))
    else $error("instr");
  bit_store_a:
    assert property (go && st |=> transfer_bit == $past(exe.a[exe.bit_sel]))
    else $error("store");
  sign_flag_a:
    assert property (go && ar |=> status_flags[4] == (status_flags[2]
      ^ status_flags[3])) else $error("sign");
  flags_keep_a:
    assert property (quiet |=> $stable(status_flags)) else $error("keep");
endmodule : csf_chk
`default_nettype wire

/* tb/csf_core_mdl.sv */
`timescale 1ns/1ps
`default_nettype none
// core execution stage: one operation per call
module csf_core_mdl (
  input wire logic clk,
  output var csf_pkg::csf_exec_type exe
);
  initial exe = '0;
  // one cycle valid, then operands scrambled
  task op(input csf_pkg::csf_op_type o, input logic [7:0] a, b,
    input logic [2:0] s);
    @(posedge clk);
    #1 exe = {1'b1, o, a, b, s};
    @(posedge clk);
    #1 exe = {1'b0, o, ~a, ~b, ~s};
  endtask : op
endmodule : csf_core_mdl
`default_nettype wire

/* tb/csf_status_flags_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module csf_status_flags_tb_top;
  logic clk, resetn, irq_pending, isr_enter, irq_return;
  logic io_wait, irq_take, transfer_bit;
  logic [7:0] status_flags, io_rdata, rd;
  logic [7:0] av[4] = '{8'hff, 8'h7f, 8'h08, 8'h80};
  logic [7:0] bv[4] = '{8'h01, 8'h01, 8'h08, 8'h80};
  wire csf_pkg::csf_exec_type exe;
  csf_pkg::csf_io_type io;
  int num_errors, cmp_count, cyc;
  csf_core_mdl core_u (.clk, .exe);
  csf_status_flags dut_u (.clk, .resetn, .exe, .io, .irq_pending,
    .isr_enter, .irq_return, .status_flags, .io_rdata, .io_wait,
    .irq_take, .transfer_bit);
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input logic [7:0] g, e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task close_out;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task iow(input logic [7:0] a, d);
    @(posedge clk);
    #1 io = {2'b01, a, d};
    @(posedge clk);
    #1 io = {2'b00, ~a, ~d};
  endtask : iow
  task ior(input logic [7:0] a);
    @(posedge clk);
    #1 io = {2'b10, a, 8'h00};
    @(posedge clk);
    #1 io = {2'b00, ~a, 8'hff};
    rd = io_rdata;
  endtask : ior
  // expected H S V N Z C of an add
  function automatic logic [7:0] addf(input logic [7:0] a, b);
    logic [8:0] s;
    logic [4:0] h;
    logic v;
    s = a + b;
    h = a[3:0] + b[3:0];
    v = a[7] == b[7] && s[7] != a[7];
    return {2'b00, h[4], s[7] ^ v, v, s[7], s[7:0] == 8'h00, s[8]};
  endfunction : addf
  // hang limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    resetn = 1'b0;
    io = '0;
    irq_pending = 1'b0;
    isr_enter = 1'b0;
    irq_return = 1'b0;
    repeat (6) @(posedge clk);
    #1 resetn = 1'b1;
    chk(status_flags, 8'h00);
    ior(8'h0f);
    chk(rd, 8'h00);
    irq_pending = 1'b1;
    iow(8'h0f, 8'h80);
    chk({io_wait, irq_take, status_flags[5:0]}, 8'hc0);
    iow(8'h0f, 8'h80);
    chk({io_wait, irq_take, 6'h00}, 8'h40);
    @(posedge clk);
    #1 isr_enter = 1'b1;
    @(posedge clk);
    #1 isr_enter = 1'b0;
    chk({status_flags[7], irq_take, 6'h00}, 8'h80);
    irq_return = 1'b1;
    @(posedge clk);
    #1 irq_return = 1'b0;
    chk({status_flags[7], irq_take, 6'h00}, 8'h80);
    iow(8'h0e, 8'h00);
    ior(8'h0e);
    chk(status_flags ^ rd, 8'h80);
    core_u.op(csf_pkg::CSF_OP_IRQ_DIS, 8'h00, 8'h00, 3'h0);
    chk({status_flags[7], irq_take, 6'h00}, 8'h00);
    core_u.op(csf_pkg::CSF_OP_IRQ_EN, 8'h00, 8'h00, 3'h0);
    chk({status_flags[7], irq_take, 6'h00}, 8'hc0);
    $display("irq test done");
    for (int i = 0; i < 4; i++) begin
      core_u.op(csf_pkg::CSF_OP_ADD, av[i], bv[i], 3'h0);
      chk({2'b00, status_flags[5:0]}, addf(av[i], bv[i]));
    end
    core_u.op(csf_pkg::CSF_OP_BIT_STORE, 8'h40, 8'h00, 3'h6);
    chk({status_flags[6], transfer_bit, 6'h00}, 8'hc0);
    iow(8'h0f, 8'h21);
    core_u.op(csf_pkg::CSF_OP_INC, 8'hff, 8'h00, 3'h0);
    chk(status_flags, 8'h23);
    iow(8'h0f, 8'h5a);
    ior(8'h0f);
    chk(rd, 8'h5a);
    core_u.op(csf_pkg::CSF_OP_FLAG_SET, 8'h00, 8'h00, 3'h2);
    chk(status_flags, 8'h5e);
    core_u.op(csf_pkg::CSF_OP_FLAG_CLR, 8'h00, 8'h00, 3'h6);
    chk(status_flags, 8'h1e);
    core_u.op(csf_pkg::CSF_OP_SUB, 8'h10, 8'h20, 3'h0);
    chk(status_flags, 8'h15);
    core_u.op(csf_pkg::CSF_OP_SBC, 8'h00, 8'h00, 3'h0);
    chk(status_flags, 8'h35);
    core_u.op(csf_pkg::CSF_OP_LOGIC, 8'h00, 8'h00, 3'h0);
    chk(status_flags, 8'h23);
    core_u.op(csf_pkg::CSF_OP_SHIFT, 8'h81, 8'h00, 3'h0);
    chk(status_flags, 8'h21);
    core_u.op(csf_pkg::CSF_OP_DEC, 8'h80, 8'h00, 3'h0);
    chk(status_flags, 8'h39);
    core_u.op(csf_pkg::CSF_OP_ADC, 8'h0f, 8'h00, 3'h0);
    chk(status_flags, 8'h20);
    $display("flag test done");
    resetn = 1'b0;
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    chk({irq_take, status_flags[6:0]}, 8'h00);
    $display("reset test done");
    close_out();
  end
endmodule : csf_status_flags_tb_top
bind csf_status_flags csf_chk chk_u (.clk, .resetn, .exe, .io,
  .irq_pending, .isr_enter, .irq_return, .status_flags, .io_wait,
  .irq_take, .transfer_bit);
`default_nettype wire
